// *** rtl/watchdog_pkg.sv ***
// Shared constants and types for the pin-strapped watchdog
package watchdog_pkg;

    // ----------------------------------------
    // Clock
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 100;

    // ----------------------------------------
    // Timeout and pulse options, in microseconds
    // ----------------------------------------
    localparam longint WINDOW_A_US = 3400;
    localparam longint WINDOW_B_US = 6800;
    localparam longint WINDOW_C_US = 108800;
    localparam longint WINDOW_D_US = 1700000;
    localparam longint WINDOW_E_US = 7000000;
    localparam longint WINDOW_F_US = 27900000;
    localparam longint PULSE_A_US = 27200;
    localparam longint PULSE_B_US = 217600;

    // Cycle counts derived from the clock period
    localparam longint WINDOW_A_CYC = WINDOW_A_US * 1000 / CLK_PERIOD_NS;
    localparam longint WINDOW_B_CYC = WINDOW_B_US * 1000 / CLK_PERIOD_NS;
    localparam longint WINDOW_C_CYC = WINDOW_C_US * 1000 / CLK_PERIOD_NS;
    localparam longint WINDOW_D_CYC = WINDOW_D_US * 1000 / CLK_PERIOD_NS;
    localparam longint WINDOW_E_CYC = WINDOW_E_US * 1000 / CLK_PERIOD_NS;
    localparam longint WINDOW_F_CYC = WINDOW_F_US * 1000 / CLK_PERIOD_NS;
    localparam longint PULSE_A_CYC = PULSE_A_US * 1000 / CLK_PERIOD_NS;
    localparam longint PULSE_B_CYC = PULSE_B_US * 1000 / CLK_PERIOD_NS;

    // ----------------------------------------
    // Filter and minimum alarm times
    // ----------------------------------------
    localparam int FILTER_ACCEPT_NS = 1000;
    localparam int GLITCH_REJECT_NS = 100;
    // Accept level after it stood below the 1 us limit, at or above 100 ns
    localparam int FILTER_CYC = (FILTER_ACCEPT_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_ALARM_NS = 20000;
    localparam int MIN_ALARM_CYC = (MIN_ALARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 32;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        WIN_A = 3'h0,
        WIN_B = 3'h1,
        WIN_C = 3'h2,
        WIN_D = 3'h3,
        WIN_E = 3'h4,
        WIN_F = 3'h5
    } window_sel_type;

    typedef enum logic [1:0] {
        ST_OFF = 2'h0,
        ST_WATCH = 2'h1,
        ST_ALARM = 2'h2
    } wd_state_type;

endpackage

// *** rtl/pin_filter.sv ***
// Two-flop synchroniser with glitch filter and edge detection
`timescale 1ns/1ps
module pin_filter #(
    parameter int STABLE_CYC = watchdog_pkg::FILTER_CYC
) (
    input wire logic mclk, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic pin_in, // Raw asynchronous pin
    output logic level_q, // Filtered level
    output logic rise, // Filtered rising edge pulse
    output logic fall // Filtered falling edge pulse
);

    logic meta_q;
    logic sync_q;
    logic [7:0] stable_q;
    logic seeded_q;

    always_ff @(posedge mclk) begin
        meta_q <= pin_in;
        sync_q <= meta_q;
    end

    // ----------------------------------------
    // Level counter filter
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            stable_q <= 8'h00;
            level_q <= 1'b0;
            seeded_q <= 1'b0;
        end else if (!seeded_q) begin
            level_q <= sync_q;
            seeded_q <= 1'b1;
        end else if (sync_q == level_q) begin
            stable_q <= 8'h00;
        end else if (stable_q >= 8'(STABLE_CYC - 1)) begin
            level_q <= sync_q;
            stable_q <= 8'h00;
        end else begin
            stable_q <= stable_q + 8'h01;
        end
    end

    logic level_prev_q;
    always_ff @(posedge mclk) begin
        if (reset) begin
            level_prev_q <= 1'b0;
        end else if (!seeded_q) begin
            // Seeded together with the level, so no false edge follows reset
            level_prev_q <= sync_q;
        end else begin
            level_prev_q <= level_q;
        end
    end

    assign rise = seeded_q && level_q && !level_prev_q;
    assign fall = seeded_q && !level_q && level_prev_q;

endmodule

// *** rtl/alarm_timer.sv ***
// Loadable down counter with expiry flag
`timescale 1ns/1ps
module alarm_timer #(
    parameter int W = watchdog_pkg::CNT_W
) (
    input wire logic mclk, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic load, // Load a new count
    input wire logic [W-1:0] load_val, // Count to load
    input wire logic hold, // Keep counter at zero
    output logic done // Count reached one, level
);

    logic [W-1:0] count_q;

    always_ff @(posedge mclk) begin
        if (reset || hold) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= load_val;
        end else if (count_q != '0) begin
            count_q <= count_q - 1'b1;
        end
    end

    assign done = (count_q == {{(W-1){1'b0}}, 1'b1});

endmodule

// *** rtl/pin_strapped_watchdog_timer.sv ***
// Watchdog top: kick window, alarm pulse and disable handling
`timescale 1ns/1ps
module pin_strapped_watchdog_timer #(
    parameter logic [2:0] WINDOW_SEL = 3'h1, // Timeout option, A..F as 0..5
    parameter bit LONG_PULSE = 1'b0, // Pulse option B when set
    parameter longint WINDOW_A_CYC = watchdog_pkg::WINDOW_A_CYC, // Option A window cycles
    parameter longint WINDOW_B_CYC = watchdog_pkg::WINDOW_B_CYC, // Option B window cycles
    parameter longint WINDOW_C_CYC = watchdog_pkg::WINDOW_C_CYC, // Option C window cycles
    parameter longint WINDOW_D_CYC = watchdog_pkg::WINDOW_D_CYC, // Option D window cycles
    parameter longint WINDOW_E_CYC = watchdog_pkg::WINDOW_E_CYC, // Option E window cycles
    parameter longint WINDOW_F_CYC = watchdog_pkg::WINDOW_F_CYC, // Option F window cycles
    parameter longint PULSE_A_CYC = watchdog_pkg::PULSE_A_CYC, // Short pulse cycles
    parameter longint PULSE_B_CYC = watchdog_pkg::PULSE_B_CYC, // Long pulse cycles
    parameter int MIN_ALARM_CYC = watchdog_pkg::MIN_ALARM_CYC // Minimum alarm low cycles
) (
    input wire logic mclk, // System clock, 10 MHz
    input wire logic reset, // Synchronous reset, active high
    input wire logic power_good, // Supply above start level, async
    input wire logic kick_in, // Kick pin from host, async
    input wire logic watch_disable_in, // Disable pin, active high, async
    output logic timeout_alarm_out_n, // Alarm pin output value, always 0
    output logic timeout_alarm_oe // Alarm pin drive enable
);

    localparam int W = watchdog_pkg::CNT_W;

    // ----------------------------------------
    // Option decode
    // ----------------------------------------
    localparam bit RISE_ONLY = (WINDOW_SEL == 3'(watchdog_pkg::WIN_A));
    localparam longint WINDOW_CYC =
        (WINDOW_SEL == 3'(watchdog_pkg::WIN_A)) ? WINDOW_A_CYC :
        (WINDOW_SEL == 3'(watchdog_pkg::WIN_B)) ? WINDOW_B_CYC :
        (WINDOW_SEL == 3'(watchdog_pkg::WIN_C)) ? WINDOW_C_CYC :
        (WINDOW_SEL == 3'(watchdog_pkg::WIN_D)) ? WINDOW_D_CYC :
        (WINDOW_SEL == 3'(watchdog_pkg::WIN_E)) ? WINDOW_E_CYC : WINDOW_F_CYC;
    localparam longint PULSE_CYC = LONG_PULSE ? PULSE_B_CYC : PULSE_A_CYC;
    localparam longint ALARM_CYC = RISE_ONLY ? WINDOW_CYC : PULSE_CYC;
    localparam logic [W-1:0] WINDOW_LOAD = W'(WINDOW_CYC);
    localparam logic [W-1:0] ALARM_LOAD = W'(ALARM_CYC);

    // ----------------------------------------
    // Input conditioning
    // ----------------------------------------
    logic kick_rise;
    logic kick_fall;
    logic dis_level;
    logic dis_rise;
    logic pg_meta_q;
    logic pg_sync_q;

    pin_filter kick_filt (
        .mclk(mclk),
        .reset(reset),
        .pin_in(kick_in),
        .level_q(),
        .rise(kick_rise),
        .fall(kick_fall)
    );

    pin_filter dis_filt (
        .mclk(mclk),
        .reset(reset),
        .pin_in(watch_disable_in),
        .level_q(dis_level),
        .rise(dis_rise),
        .fall()
    );

    always_ff @(posedge mclk) begin
        pg_meta_q <= power_good;
        pg_sync_q <= pg_meta_q;
    end

    // ----------------------------------------
    // State machine
    // ----------------------------------------
    watchdog_pkg::wd_state_type state_q;
    watchdog_pkg::wd_state_type state_d;
    logic [15:0] low_cnt_q;
    logic min_met;
    logic timer_done;
    logic timer_load;
    logic [W-1:0] timer_val;
    logic kick_valid;

    assign min_met = (low_cnt_q >= 16'(MIN_ALARM_CYC));
    assign kick_valid = kick_rise || (!RISE_ONLY && kick_fall);

    always_comb begin
        state_d = state_q;
        timer_load = 1'b0;
        timer_val = WINDOW_LOAD;
        case (state_q)
            watchdog_pkg::ST_OFF: begin
                if (pg_sync_q && !dis_level) begin
                    state_d = watchdog_pkg::ST_WATCH;
                    timer_load = 1'b1;
                end
            end
            watchdog_pkg::ST_WATCH: begin
                if (dis_level || dis_rise) begin
                    state_d = watchdog_pkg::ST_OFF;
                end else if (timer_done) begin
                    state_d = watchdog_pkg::ST_ALARM;
                    timer_load = 1'b1;
                    timer_val = ALARM_LOAD;
                end else if (kick_valid) begin
                    timer_load = 1'b1;
                end
            end
            watchdog_pkg::ST_ALARM: begin
                if (dis_level && min_met) begin
                    state_d = watchdog_pkg::ST_OFF;
                end else if (RISE_ONLY && kick_rise && min_met && !dis_level) begin
                    state_d = watchdog_pkg::ST_WATCH;
                    timer_load = 1'b1;
                end else if (timer_done && min_met && !dis_level) begin
                    state_d = watchdog_pkg::ST_WATCH;
                    timer_load = 1'b1;
                end
                // Kicks otherwise ignored while the alarm is on
            end
            default: begin
                state_d = watchdog_pkg::ST_OFF;
            end
        endcase
        if (!pg_sync_q) begin
            state_d = watchdog_pkg::ST_OFF;
            timer_load = 1'b0;
        end
    end

    logic rise_pending_q;
    // Rising kick during the minimum alarm time ends the alarm at the minimum
    always_ff @(posedge mclk) begin
        if (reset || state_q != watchdog_pkg::ST_ALARM) begin
            rise_pending_q <= 1'b0;
        end else if (RISE_ONLY && kick_rise && !min_met) begin
            rise_pending_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= watchdog_pkg::ST_OFF;
        end else if (rise_pending_q && min_met && state_q == watchdog_pkg::ST_ALARM && !dis_level) begin
            state_q <= watchdog_pkg::ST_WATCH;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || state_q != watchdog_pkg::ST_ALARM) begin
            low_cnt_q <= 16'h0000;
        end else if (!min_met) begin
            low_cnt_q <= low_cnt_q + 16'h0001;
        end
    end

    logic pend_load;
    assign pend_load = rise_pending_q && min_met && state_q == watchdog_pkg::ST_ALARM && !dis_level;

    alarm_timer #(.W(W)) timer (
        .mclk(mclk),
        .reset(reset),
        .load(timer_load || pend_load),
        .load_val(pend_load ? WINDOW_LOAD : timer_val),
        .hold(state_q == watchdog_pkg::ST_OFF && state_d == watchdog_pkg::ST_OFF),
        .done(timer_done)
    );

    // ----------------------------------------
    // Open-drain output
    // ----------------------------------------
    logic drive_q;
    always_ff @(posedge mclk) begin
        if (reset) begin
            drive_q <= 1'b0;
        end else begin
            drive_q <= (state_d == watchdog_pkg::ST_ALARM) && !pend_load;
        end
    end

    assign timeout_alarm_out_n = 1'b0;
    assign timeout_alarm_oe = drive_q;

endmodule

// *** testbench/wd_properties.sv ***
// Assertions on the watchdog alarm pin
`timescale 1ns/1ps
module wd_properties #(
    parameter longint WIN_CYC = 200,
    parameter longint PULSE_CYC = 300,
    parameter int MIN_CYC = 200,
    parameter bit RISE_ONLY_OPT = 1'b0
) (
    input wire logic mclk, // Clock
    input wire logic reset, // Sync reset
    input wire logic power_good, // Supply good
    input wire logic kick_in, // Kick pin
    input wire logic watch_disable_in, // Disable pin
    input wire logic timeout_alarm_out_n, // Alarm data
    input wire logic timeout_alarm_oe // Alarm drive
);
    logic [31:0] hi_q;
    logic [31:0] lo_q;
    logic kick_q;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    // ----
    // Length of the current alarm and of the quiet time before it
    // ----
    always_ff @(posedge mclk) begin
        if (reset || !timeout_alarm_oe) begin
            hi_q <= 32'h0;
        end else begin
            hi_q <= hi_q + 32'h1;
        end
    end
    always_ff @(posedge mclk) begin
        kick_q <= kick_in;
        if (reset || !power_good || watch_disable_in || timeout_alarm_oe || (kick_in && !kick_q) ||
            (!RISE_ONLY_OPT && !kick_in && kick_q)) begin
            lo_q <= 32'h0;
        end else begin
            lo_q <= lo_q + 32'h1;
        end
    end
    sequence dis_settled;
        watch_disable_in [*8] ##1 watch_disable_in [*6];
    endsequence
    open_drain_a: assert property (timeout_alarm_out_n == 1'b0)
        else $error("alarm data not low");
    reset_idle_a: assert property (disable iff (1'b0) reset |=> !timeout_alarm_oe)
        else $error("alarm after reset");
    power_idle_a: assert property (!power_good [*6] |-> !timeout_alarm_oe)
        else $error("alarm without power");
    disabled_quiet_a: assert property (dis_settled ##0 !timeout_alarm_oe |=> !timeout_alarm_oe)
        else $error("alarm while disabled");
    disable_release_a: assert property (dis_settled ##0 timeout_alarm_oe |-> hi_q <= MIN_CYC + 1)
        else $error("alarm not released");
    min_alarm_a: assert property ($fell(timeout_alarm_oe) && power_good |-> hi_q >= MIN_CYC)
        else $error("alarm too short");
    alarm_max_a: assert property ($fell(timeout_alarm_oe) |-> hi_q <= PULSE_CYC + 1)
        else $error("alarm too long");
    full_pulse_a: assert property ($fell(timeout_alarm_oe) && !watch_disable_in && !RISE_ONLY_OPT |->
        hi_q inside {[PULSE_CYC - 1:PULSE_CYC + 1]})
        else $error("pulse length wrong");
    window_min_a: assert property ($rose(timeout_alarm_oe) |-> lo_q >= WIN_CYC - 2)
        else $error("alarm too early");
    window_max_a: assert property (lo_q <= WIN_CYC + 12)
        else $error("alarm too late");
endmodule
// Counts follow the option that each instance is built with
bind pin_strapped_watchdog_timer wd_properties #(.WIN_CYC(WINDOW_CYC), .PULSE_CYC(ALARM_CYC),
    .MIN_CYC(MIN_ALARM_CYC), .RISE_ONLY_OPT(RISE_ONLY)) chk_u (.mclk(mclk), .reset(reset),
    .power_good(power_good), .kick_in(kick_in),
    .watch_disable_in(watch_disable_in), .timeout_alarm_out_n(timeout_alarm_out_n),
    .timeout_alarm_oe(timeout_alarm_oe));

// *** testbench/host_model.sv ***
// Host model: kicks the watchdog, pull-up on the alarm wire
`timescale 1ns/1ps
module host_model #(
    parameter int GAP = 150
) (
    input wire logic mclk, // Clock
    input wire logic alarm_oe, // Alarm wire pulled low
    input wire logic kick_en, // Kick periodically
    input wire logic kick_lvl, // Kick level when idle
    output logic kick_in, // Kick pin
    output logic alarm_wire // Resolved alarm wire
);
    int gap_q = 0;
    initial kick_in = 1'b1;
    // ----
    // Wire and kicks
    // ----
    assign alarm_wire = alarm_oe ? 1'b0 : 1'b1;
    // Gap count paused while the wire is low, so no kicks then
    always @(posedge mclk) begin
        if (!kick_en) begin
            kick_in <= kick_lvl;
            gap_q <= 0;
        end else if (alarm_wire) begin
            gap_q <= (gap_q == GAP - 1) ? 0 : gap_q + 1;
            if (gap_q == GAP - 1) begin
                kick_in <= ~kick_in;
            end
        end
    end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the pin-strapped watchdog
`timescale 1ns/1ps
module testbench;
    localparam int WIN = 200;
    localparam int PULSE = 300;
    localparam int MIN_LOW = 200;
    localparam int WIN_A = 400;
    logic mclk, reset, power_good, watch_disable_in, kick_en, kick_lvl;
    logic kick_in, alarm_oe, out_n, alarm_wire;
    logic kick_a, oe_a, out_a_n;
    int fails = 0;
    int comparisons = 0;
    int cyc = 0;
    int n, highs;
    pin_strapped_watchdog_timer #(.WINDOW_SEL(3'h1), .LONG_PULSE(1'b0), .WINDOW_B_CYC(WIN),
        .PULSE_A_CYC(PULSE), .MIN_ALARM_CYC(MIN_LOW)) dut_u (.mclk(mclk), .reset(reset),
        .power_good(power_good), .kick_in(kick_in), .watch_disable_in(watch_disable_in),
        .timeout_alarm_out_n(out_n), .timeout_alarm_oe(alarm_oe));
    host_model #(.GAP(150)) host_u (.mclk(mclk), .alarm_oe(alarm_oe), .kick_en(kick_en),
        .kick_lvl(kick_lvl), .kick_in(kick_in), .alarm_wire(alarm_wire));
    // Rising-edge-only option, kicked directly by the bench
    pin_strapped_watchdog_timer #(.WINDOW_SEL(3'h0), .WINDOW_A_CYC(WIN_A), .MIN_ALARM_CYC(MIN_LOW)) dut_a_u (
        .mclk(mclk), .reset(reset), .power_good(power_good), .kick_in(kick_a),
        .watch_disable_in(watch_disable_in), .timeout_alarm_out_n(out_a_n), .timeout_alarm_oe(oe_a));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    // ----
    // Helpers
    // ----
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic clocks(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic wait_oe(input logic val, output int cnt);
        cnt = 0;
        #1;
        while (alarm_oe !== val && cnt < 1000) begin
            clocks(1);
            cnt++;
        end
    endtask
    task automatic wait_a(input logic val, output int cnt);
        cnt = 0;
        #1;
        while (oe_a !== val && cnt < 1000) begin
            clocks(1);
            cnt++;
        end
    endtask
    task automatic count_high(input int k);
        highs = 0;
        repeat (k) begin
            clocks(1);
            highs += int'(alarm_oe !== 1'b0);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_startup;
        clocks(20);
        check("idle alarm", alarm_oe, 1'b0);
        @(posedge mclk) power_good <= 1'b1;
        wait_oe(1'b1, n);
        check("first window", 32'(n >= WIN && n <= WIN + 12), 32'h1);
        check("wire low", alarm_wire, 1'b0);
        check("data low", out_n, 1'b0);
        wait_oe(1'b0, n);
        check("pulse", 32'(n >= PULSE - 1 && n <= PULSE + 1), 32'h1);
        check("wire high", alarm_wire, 1'b1);
        wait_oe(1'b1, n);
        check("next window", 32'(n >= WIN - 2 && n <= WIN + 2), 32'h1);
        wait_oe(1'b0, n);
        $display("startup done");
    endtask
    task automatic t_kick;
        @(posedge mclk) kick_en <= 1'b1;
        count_high(1500);
        check("kicked alarm", 32'(highs), 32'h0);
        @(posedge mclk) kick_lvl <= kick_in;
        @(posedge mclk) kick_en <= 1'b0;
        $display("kick done");
    endtask
    task automatic t_ignore;
        wait_oe(1'b1, n);
        repeat (5) begin
            clocks(19);
            @(posedge mclk) kick_lvl <= ~kick_lvl;
        end
        wait_oe(1'b0, n);
        check("kicked pulse", 32'(n + 100 >= PULSE - 1 && n + 100 <= PULSE + 1), 32'h1);
        $display("ignore done");
    endtask
    task automatic t_disable;
        @(posedge mclk) watch_disable_in <= 1'b1;
        count_high(1000);
        check("disabled alarm", 32'(highs), 32'h0);
        @(posedge mclk) watch_disable_in <= 1'b0;
        wait_oe(1'b1, n);
        check("fresh window", 32'(n >= WIN && n <= WIN + 12), 32'h1);
        clocks(19);
        @(posedge mclk) watch_disable_in <= 1'b1;
        wait_oe(1'b0, n);
        check("early release", 32'(n + 20 >= MIN_LOW && n + 20 <= MIN_LOW + 12), 32'h1);
        count_high(300);
        check("held off", 32'(highs), 32'h0);
        @(posedge mclk) watch_disable_in <= 1'b0;
        $display("disable done");
    endtask
    task automatic t_reset;
        wait_oe(1'b1, n);
        @(posedge mclk) reset <= 1'b1;
        clocks(2);
        check("reset alarm", alarm_oe, 1'b0);
        @(posedge mclk) reset <= 1'b0;
        wait_oe(1'b1, n);
        check("restart window", 32'(n >= WIN && n <= WIN + 14), 32'h1);
        wait_oe(1'b0, n);
        @(posedge mclk) power_good <= 1'b0;
        count_high(300);
        check("unpowered alarm", 32'(highs), 32'h0);
        @(posedge mclk) power_good <= 1'b1;
        $display("reset done");
    endtask
    task automatic t_rise;
        wait_a(1'b0, n);
        wait_a(1'b1, n);
        check("rise-only data", out_a_n, 1'b0);
        wait_a(1'b0, n);
        check("rise-only alarm", 32'(n >= WIN_A - 1 && n <= WIN_A + 1), 32'h1);
        clocks(99);
        @(posedge mclk) kick_a <= 1'b0;
        wait_a(1'b1, n);
        check("falling kick", 32'(n + 100 >= WIN_A - 1 && n + 100 <= WIN_A + 1), 32'h1);
        clocks(20);
        @(posedge mclk) kick_a <= 1'b1;
        wait_a(1'b0, n);
        check("early kick", 32'(n + 21 >= MIN_LOW && n + 21 <= MIN_LOW + 12), 32'h1);
        @(posedge mclk) kick_a <= 1'b0;
        wait_a(1'b1, n);
        clocks(249);
        @(posedge mclk) kick_a <= 1'b1;
        wait_a(1'b0, n);
        check("late kick", 32'(n >= 4 && n <= 12), 32'h1);
        $display("rise-only done");
    endtask
    initial begin
        reset = 1'b1;
        power_good = 1'b0;
        watch_disable_in = 1'b0;
        kick_en = 1'b0;
        kick_lvl = 1'b1;
        kick_a = 1'b1;
        clocks(6);
        @(posedge mclk) reset <= 1'b0;
        t_startup();
        t_kick();
        t_ignore();
        t_disable();
        t_reset();
        t_rise();
        tally_and_finish();
    end
endmodule
